// File: rtl/limit_reach.sv
`timescale 1ns/1ps
// signed compare of position against a virtual limit
module limit_reach #(
	parameter int unsigned WIDTH = 32
) (
	// operands
	input  wire logic [WIDTH-1:0] pos,
	input  wire logic [WIDTH-1:0] limit,
	input  wire logic             toward_neg,
	// limit touched or passed
	output logic                  reached
);
	// left limit is reached from above, right limit from below
	always_comb begin
		if (toward_neg) begin
			reached = $signed(pos) <= $signed(limit);
		end else begin
			reached = $signed(pos) >= $signed(limit);
		end
	end

endmodule : limit_reach

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for asynchronous pins
module pin_sync #(
	parameter int unsigned WIDTH = 3
) (
	// clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// pins in, clean levels out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;   // first stage, read only by second
		logic [WIDTH-1:0] clean;  // second stage
	} sync_t;

	sync_t s_reg;
	sync_t s_next;

	// shift on every enabled cycle
	always_comb begin
		s_next = s_reg;
		if (ce) begin
			s_next.meta  = d;
			s_next.clean = s_reg.meta;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.clean;

endmodule : pin_sync

// File: rtl/reference_switch_stop_unit.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module reference_switch_stop_unit (
	// clock, reset, enable
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	// apb slave
	input  wire switch_stop_pkg::apb_req_t apb_req,
	output switch_stop_pkg::apb_rsp_t      apb_rsp,
	// end switch and stall pins
	input  wire logic                      stop_left_pin,
	input  wire logic                      stop_right_pin,
	input  wire logic                      stall_pin,
	// ramp generator side
	input  wire switch_stop_pkg::motion_t  motion,
	output switch_stop_pkg::stop_cmd_t     stop_cmd
);
	import switch_stop_pkg::*;

	// whole state of the block
	typedef struct packed {
		logic [CFG_W-1:0]  cfg;        // switch configuration
		logic [DATA_W-1:0] lim_l;      // left virtual limit
		logic [DATA_W-1:0] lim_r;      // right virtual limit
		logic [DATA_W-1:0] decel;      // stop deceleration
		logic [DATA_W-1:0] xlatch;     // captured ramp position
		logic [DATA_W-1:0] elatch;     // captured encoder position
		logic              flag_ll;    // left capture ready
		logic              flag_lr;    // right capture ready
		logic              stall_halt_flag;
		logic [1:0]        act_prev;   // polarity-corrected levels
		logic              stall_prev; // last stall level
		logic              stop_l;     // left stop in effect
		logic              stop_r;     // right stop in effect
		logic              hard;       // hard stop command
		logic              ramp;       // ramped stop command
		logic              lim_halt;   // virtual limit halt
		logic [DATA_W-1:0] lim_pos;    // halt target
		logic [DATA_W-1:0] prdata;     // read data
		logic              rd_ok;      // read data loaded for this transfer
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic [2:0]       sync_q;     // clean pin levels
	logic             lim_l_hit;  // at or below left limit
	logic             lim_r_hit;  // at or above right limit
	logic [1:0]       act;        // switch active after polarity
	logic [1:0]       rise;       // going active
	logic [1:0]       fall;       // going inactive
	logic             cap_l;      // left capture event
	logic             cap_r;      // right capture event
	logic             stop_l_c;   // left stop condition
	logic             stop_r_c;   // right stop condition
	logic             stall_ev;   // stall edge while enabled
	logic             vlim_l;     // left virtual halt
	logic             vlim_r;     // right virtual halt
	logic             any_stop;   // any switch or stall stop
	logic [IDX_W-1:0] idx;        // register index of paddr
	logic             acc_done;   // access phase completes
	logic             rd_flags;   // flag register read completes
	logic             wr_en;      // write completes
	logic             clr_ll;     // left capture flag was reported
	logic             clr_lr;     // right capture flag was reported
	logic             clr_st;     // stall flag was reported

	// word index of a byte address
	function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[ADDR_W-1:2];
	endfunction : reg_index

	// known register at this address
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a[1:0] == 2'h0) && (reg_index(a) >= IDX_CFG) && (reg_index(a) <= IDX_ELATCH);
	endfunction : mapped

	// raw pins are asynchronous, never read before the second stage
	pin_sync #(
		.WIDTH (3)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.ce    (ce),
		.d     ({stall_pin, stop_right_pin, stop_left_pin}),
		.q     (sync_q)
	);

	// left limit is approached moving negative
	limit_reach #(
		.WIDTH (DATA_W)
	) u_lim_l (
		.pos        (motion.ramp_pos),
		.limit      (s_reg.lim_l),
		.toward_neg (1'b1),
		.reached    (lim_l_hit)
	);

	// right limit is approached moving positive
	limit_reach #(
		.WIDTH (DATA_W)
	) u_lim_r (
		.pos        (motion.ramp_pos),
		.limit      (s_reg.lim_r),
		.toward_neg (1'b0),
		.reached    (lim_r_hit)
	);

	// switch levels, edges and stop conditions
	always_comb begin
		act[0] = sync_q[0] ^ s_reg.cfg[CFG_POL_L];
		act[1] = sync_q[1] ^ s_reg.cfg[CFG_POL_R];
		// a polarity write can look like an edge; software should change it idle
		rise  = act & ~s_reg.act_prev;
		fall  = ~act & s_reg.act_prev;
		cap_l = (rise[0] & s_reg.cfg[CFG_CAP_L_ACT])
		      | (fall[0] & s_reg.cfg[CFG_CAP_L_INACT]);
		cap_r = (rise[1] & s_reg.cfg[CFG_CAP_R_ACT])
		      | (fall[1] & s_reg.cfg[CFG_CAP_R_INACT]);
		// exchange moves each switch to the other travel direction
		if (s_reg.cfg[CFG_SIDE_XCHG]) begin
			stop_l_c = s_reg.cfg[CFG_EN_L] & act[0] & ~motion.dir_neg;
			stop_r_c = s_reg.cfg[CFG_EN_R] & act[1] & motion.dir_neg;
		end else begin
			stop_l_c = s_reg.cfg[CFG_EN_L] & act[0] & motion.dir_neg;
			stop_r_c = s_reg.cfg[CFG_EN_R] & act[1] & ~motion.dir_neg;
		end
		stall_ev = sync_q[2] & ~s_reg.stall_prev & s_reg.cfg[CFG_HALT_STALL];
		vlim_l   = s_reg.cfg[CFG_VLIM_L] & motion.dir_neg & lim_l_hit;
		vlim_r   = s_reg.cfg[CFG_VLIM_R] & ~motion.dir_neg & lim_r_hit;
		any_stop = stop_l_c | stop_r_c | s_reg.stall_halt_flag | stall_ev;
	end

	// bus decode
	always_comb begin
		idx      = reg_index(apb_req.paddr);
		acc_done = ce & s_reg.rd_ok & apb_req.psel & apb_req.penable;
		rd_flags = acc_done & ~apb_req.pwrite & (idx == IDX_FLAGS);
		wr_en    = acc_done & apb_req.pwrite;
		// read data is snapped in setup, so only flags it carried may clear;
		// an event landing on the setup edge would otherwise be lost unseen
		clr_ll   = rd_flags & s_reg.prdata[FLG_CAP_L];
		clr_lr   = rd_flags & s_reg.prdata[FLG_CAP_R];
		clr_st   = rd_flags & s_reg.prdata[FLG_STALL];
	end

	// next state
	always_comb begin
		s_next = s_reg;
		if (ce) begin
			s_next.act_prev   = act;
			s_next.stall_prev = sync_q[2];
			s_next.stop_l     = stop_l_c;
			s_next.stop_r     = stop_r_c;
			// hard stop zeroes speed, ramped stop uses the stop rate
			s_next.hard       = any_stop & ~s_reg.cfg[CFG_RAMPED];
			s_next.ramp       = any_stop & s_reg.cfg[CFG_RAMPED];
			// ramp generator plans its stop onto this target
			s_next.lim_halt   = vlim_l | vlim_r;
			s_next.lim_pos    = vlim_l ? s_reg.lim_l : s_reg.lim_r;
			// captures taken in the edge cycle
			if (cap_l | cap_r) begin
				s_next.xlatch = motion.ramp_pos;
				if (s_reg.cfg[CFG_CAP_ENC]) begin
					s_next.elatch = motion.enc_pos;
				end
			end
			// sticky flags: a new event beats the clearing read
			s_next.flag_ll = cap_l | (s_reg.flag_ll & ~clr_ll);
			s_next.flag_lr = cap_r | (s_reg.flag_lr & ~clr_lr);
			s_next.stall_halt_flag = stall_ev | (s_reg.stall_halt_flag & ~clr_st);
			// register writes
			if (wr_en) begin
				unique case (idx)
					IDX_CFG: begin
						s_next.cfg = apb_req.pwdata[CFG_W-1:0];
					end
					IDX_LIM_L: begin
						s_next.lim_l = apb_req.pwdata;
					end
					IDX_LIM_R: begin
						s_next.lim_r = apb_req.pwdata;
					end
					IDX_DECEL: begin
						s_next.decel = apb_req.pwdata;
					end
					default: begin
						// read-only or unmapped, write dropped
					end
				endcase
			end
			// read data is fetched once per transfer, before pready
			if (acc_done) begin
				s_next.rd_ok = 1'b0;
			end else if (apb_req.psel && !s_reg.rd_ok) begin
				s_next.rd_ok = 1'b1;
				unique case (idx)
					IDX_CFG: begin
						s_next.prdata = {{(DATA_W-CFG_W){1'b0}}, s_reg.cfg};
					end
					IDX_FLAGS: begin
						s_next.prdata = {{(DATA_W-FLAG_W){1'b0}},
							s_reg.stall_halt_flag, s_reg.stop_r, s_reg.stop_l,
							s_reg.flag_lr, s_reg.flag_ll,
							s_reg.act_prev[1],
							s_reg.act_prev[0]};
					end
					IDX_LIM_L: begin
						s_next.prdata = s_reg.lim_l;
					end
					IDX_LIM_R: begin
						s_next.prdata = s_reg.lim_r;
					end
					IDX_DECEL: begin
						s_next.prdata = s_reg.decel;
					end
					IDX_XLATCH: begin
						s_next.prdata = s_reg.xlatch;
					end
					IDX_ELATCH: begin
						s_next.prdata = s_reg.elatch;
					end
					default: begin
						s_next.prdata = WORD_RESET;
					end
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg       <= '0;
			s_reg.cfg   <= CFG_RESET;
			s_reg.lim_l <= WORD_RESET;
			s_reg.lim_r <= WORD_RESET;
			s_reg.decel <= WORD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs
	always_comb begin
		apb_rsp.prdata      = s_reg.prdata;
		apb_rsp.pready      = ce & s_reg.rd_ok;
		apb_rsp.pslverr     = acc_done & ~mapped(apb_req.paddr);
		stop_cmd.hard_stop  = s_reg.hard;
		stop_cmd.ramp_stop  = s_reg.ramp;
		stop_cmd.stop_decel = s_reg.decel;
		stop_cmd.limit_halt = s_reg.lim_halt;
		stop_cmd.limit_pos  = s_reg.lim_pos;
	end

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence left_active_edge;
		ce && rise[0] && s_reg.cfg[CFG_CAP_L_ACT];
	endsequence

	sequence stall_edge;
		ce && sync_q[2] && !s_reg.stall_prev && s_reg.cfg[CFG_HALT_STALL];
	endsequence

	left_gate_a: assert property (ce && !s_reg.cfg[CFG_EN_L] |=> !s_reg.stop_l)
		else $error("left stop while disabled");
	right_gate_a: assert property (ce && !s_reg.cfg[CFG_EN_R] |=> !s_reg.stop_r)
		else $error("right stop while disabled");
	left_pol_a: assert property (ce |=> s_reg.act_prev[0] == $past(sync_q[0] ^ s_reg.cfg[CFG_POL_L]))
		else $error("left polarity wrong");
	side_plain_a: assert property (ce && act[0] && !s_reg.cfg[CFG_SIDE_XCHG] && !motion.dir_neg
		|=> !s_reg.stop_l)
		else $error("left stops positive motion");
	side_xchg_a: assert property (ce && act[1] && s_reg.cfg[CFG_EN_R] && s_reg.cfg[CFG_SIDE_XCHG]
		&& motion.dir_neg |=> s_reg.stop_r)
		else $error("exchanged right not stopping negative");
	stop_kind_a: assert property (ce && stop_l_c |=> (s_reg.hard != s_reg.ramp)
		&& (s_reg.ramp == $past(s_reg.cfg[CFG_RAMPED])))
		else $error("wrong stop kind");
	left_capture_a: assert property (left_active_edge |=> s_reg.flag_ll
		&& s_reg.xlatch == $past(motion.ramp_pos))
		else $error("left capture missing");
	enc_hold_a: assert property (ce && (cap_l || cap_r) && !s_reg.cfg[CFG_CAP_ENC]
		|=> $stable(s_reg.elatch))
		else $error("encoder captured while off");
	stall_flag_a: assert property (stall_edge |=> s_reg.stall_halt_flag ##1 (s_reg.hard || s_reg.ramp))
		else $error("stall did not stop");
	flag_clear_a: assert property (clr_ll && !cap_l |=> !s_reg.flag_ll)
		else $error("left flag not cleared by read");
	stall_clear_a: assert property (clr_st && !stall_ev |=> !s_reg.stall_halt_flag)
		else $error("stall flag not cleared by read");
	right_capture_a: assert property (ce && rise[1] && s_reg.cfg[CFG_CAP_R_ACT] |=> s_reg.flag_lr
		&& s_reg.xlatch == $past(motion.ramp_pos))
		else $error("right capture missing");
	vlim_halt_a: assert property (ce && vlim_r && !vlim_l |=> s_reg.lim_halt
		&& s_reg.lim_pos == $past(s_reg.lim_r))
		else $error("right limit halt missing");

endmodule : reference_switch_stop_unit

// File: rtl/switch_stop_pkg.sv
package switch_stop_pkg;

	// bus and register widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W  = 10;
	localparam int unsigned CFG_W  = 14;
	localparam int unsigned FLAG_W = 7;

	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CFG    = 10'h040;
	localparam logic [IDX_W-1:0] IDX_FLAGS  = 10'h041;
	localparam logic [IDX_W-1:0] IDX_LIM_L  = 10'h042;
	localparam logic [IDX_W-1:0] IDX_LIM_R  = 10'h043;
	localparam logic [IDX_W-1:0] IDX_DECEL  = 10'h044;
	localparam logic [IDX_W-1:0] IDX_XLATCH = 10'h045;
	localparam logic [IDX_W-1:0] IDX_ELATCH = 10'h046;

	// configuration field positions
	localparam int CFG_EN_L        = 0;
	localparam int CFG_EN_R        = 1;
	localparam int CFG_POL_L       = 2;
	localparam int CFG_POL_R       = 3;
	localparam int CFG_SIDE_XCHG   = 4;
	localparam int CFG_RAMPED      = 5;
	localparam int CFG_VLIM_L      = 6;
	localparam int CFG_VLIM_R      = 7;
	localparam int CFG_CAP_L_ACT   = 8;
	localparam int CFG_CAP_L_INACT = 9;
	localparam int CFG_CAP_R_ACT   = 10;
	localparam int CFG_CAP_R_INACT = 11;
	localparam int CFG_CAP_ENC     = 12;
	localparam int CFG_HALT_STALL  = 13;

	// flag field positions
	localparam int FLG_ACT_L   = 0;
	localparam int FLG_ACT_R   = 1;
	localparam int FLG_CAP_L   = 2;
	localparam int FLG_CAP_R   = 3;
	localparam int FLG_STOP_L  = 4;
	localparam int FLG_STOP_R  = 5;
	localparam int FLG_STALL   = 6;

	// reset values
	localparam logic [CFG_W-1:0]  CFG_RESET  = 14'h0000;
	localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

	// apb request from the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} apb_rsp_t;

	// positions and direction from the ramp generator and encoder
	typedef struct packed {
		logic [DATA_W-1:0] ramp_pos;
		logic [DATA_W-1:0] enc_pos;
		logic              dir_neg;
	} motion_t;

	// stop commands toward the ramp generator
	typedef struct packed {
		logic              hard_stop;
		logic              ramp_stop;
		logic [DATA_W-1:0] stop_decel;
		logic              limit_halt;
		logic [DATA_W-1:0] limit_pos;
	} stop_cmd_t;

endpackage : switch_stop_pkg

// File: testbench/reference_switch_stop_unit_tb.sv
`timescale 1ns/1ps
module reference_switch_stop_unit_tb;
	import switch_stop_pkg::*;
	// clock, reset, bus and motion
	logic              pclk;
	logic              presetn;
	apb_req_t          req;
	apb_rsp_t          rsp;
	motion_t           mot;
	stop_cmd_t         cmd;
	// wanted switch state and pins
	logic              l_on, r_on, s_on, lo_l, lo_r;
	logic              pin_l, pin_r, pin_s;
	logic              ce_in;
	// bookkeeping
	int                n_errors;
	int                total_checks;
	logic [DATA_W-1:0] rd;
	logic              er;

	reference_switch_stop_unit dut (.pclk(pclk), .presetn(presetn), .ce(ce_in),
		.apb_req(req), .apb_rsp(rsp), .stop_left_pin(pin_l), .stop_right_pin(pin_r),
		.stall_pin(pin_s), .motion(mot), .stop_cmd(cmd));
	switch_partner sw_model (.pclk(pclk), .left_on(l_on), .right_on(r_on), .stall_on(s_on),
		.low_l(lo_l), .low_r(lo_r), .stop_left_pin(pin_l), .stop_right_pin(pin_r),
		.stall_pin(pin_s));

	// free-running 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// verdict, the only place the run ends
	task automatic tally_and_finish;
		if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// compare one value, four-state exact
	task automatic chk(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
		int n;
		@(posedge pclk);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= {idx, 2'b00};
		req.pwdata  <= wd;
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		// a slave that never answers ends the run
		if (n >= 50) begin
			n_errors++;
			tally_and_finish();
		end
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// read a register and compare
	task automatic rdchk(input string what, input logic [IDX_W-1:0] idx,
		input logic [DATA_W-1:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(what, exp, rd);
	endtask : rdchk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc

	// set the switches and direction just after an edge
	task automatic sw(input logic l, input logic r, input logic s, input logic neg);
		@(posedge pclk);
		l_on        <= l;
		r_on        <= r;
		s_on        <= s;
		mot.dir_neg <= neg;
	endtask : sw

	// program config, let pins settle, clear sticky flags
	task automatic settle(input logic [DATA_W-1:0] cfg);
		apb(1'b1, IDX_CFG, cfg);
		wait_cyc(5);
		apb(1'b0, IDX_FLAGS, 32'h0000_0000);
	endtask : settle

	// stop outputs in one go
	task automatic stops(input logic h, input logic r);
		chk("hard_stop", {31'h0, h}, {31'h0, cmd.hard_stop});
		chk("ramp_stop", {31'h0, r}, {31'h0, cmd.ramp_stop});
	endtask : stops

	// reset values, widths, read-only and unmapped places
	task automatic t_regs;
		rdchk("cfg reset", IDX_CFG, 32'h0000_0000);
		rdchk("decel reset", IDX_DECEL, 32'h0000_0000);
		apb(1'b1, IDX_CFG, 32'hFFFF_FFFF);
		rdchk("cfg width", IDX_CFG, 32'h0000_3FFF);
		settle(32'h0000_0000);
		apb(1'b0, 10'h047, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, er});
		chk("unmapped data", 32'h0000_0000, rd);
		apb(1'b1, IDX_FLAGS, 32'hFFFF_FFFF);
		rdchk("flags ro", IDX_FLAGS, 32'h0000_0000);
	endtask : t_regs

	// left hard stop with capture on both edges
	task automatic t_left;
		mot.ramp_pos <= 32'h0000_1234;
		mot.enc_pos  <= 32'h0000_5678;
		sw(1'b0, 1'b0, 1'b0, 1'b1);
		settle(32'h0000_1101);
		sw(1'b1, 1'b0, 1'b0, 1'b1);
		wait_cyc(5);
		stops(1'b1, 1'b0);
		rdchk("flags left", IDX_FLAGS, 32'h0000_0015);
		rdchk("xlatch", IDX_XLATCH, 32'h0000_1234);
		rdchk("elatch", IDX_ELATCH, 32'h0000_5678);
		rdchk("flags clr", IDX_FLAGS, 32'h0000_0011);
		sw(1'b1, 1'b0, 1'b0, 1'b0);
		wait_cyc(3);
		stops(1'b0, 1'b0);
		apb(1'b1, IDX_CFG, 32'h0000_0200);
		mot.ramp_pos <= 32'h0000_2222;
		sw(1'b0, 1'b0, 1'b0, 1'b0);
		wait_cyc(5);
		rdchk("flags inact", IDX_FLAGS, 32'h0000_0004);
		rdchk("xlatch inact", IDX_XLATCH, 32'h0000_2222);
		rdchk("elatch kept", IDX_ELATCH, 32'h0000_5678);
	endtask : t_left

	// right switch active low, sides exchanged, ramped stop
	task automatic t_right;
		@(posedge pclk);
		lo_r <= 1'b1;
		apb(1'b1, IDX_DECEL, 32'h0000_0100);
		settle(32'h0000_083A);
		sw(1'b0, 1'b1, 1'b0, 1'b1);
		wait_cyc(5);
		stops(1'b0, 1'b1);
		chk("stop_decel", 32'h0000_0100, cmd.stop_decel);
		rdchk("flags right", IDX_FLAGS, 32'h0000_0022);
		mot.ramp_pos <= 32'h0000_3333;
		sw(1'b0, 1'b0, 1'b0, 1'b1);
		wait_cyc(5);
		stops(1'b0, 1'b0);
		rdchk("flags r inact", IDX_FLAGS, 32'h0000_0008);
		rdchk("xlatch r", IDX_XLATCH, 32'h0000_3333);
		@(posedge pclk);
		lo_r <= 1'b0;
	endtask : t_right

	// switches active but not enabled; left active low
	task automatic t_disabled;
		@(posedge pclk);
		lo_l <= 1'b1;
		sw(1'b1, 1'b0, 1'b0, 1'b1);
		settle(32'h0000_0404);
		mot.ramp_pos <= 32'h0000_4444;
		sw(1'b1, 1'b1, 1'b0, 1'b0);
		wait_cyc(5);
		stops(1'b0, 1'b0);
		rdchk("flags dis", IDX_FLAGS, 32'h0000_000B);
		rdchk("xlatch r act", IDX_XLATCH, 32'h0000_4444);
		@(posedge pclk);
		lo_l <= 1'b0;
		sw(1'b0, 1'b0, 1'b0, 1'b0);
	endtask : t_disabled

	// stall report stops the motor until the flag is read
	task automatic t_stall;
		settle(32'h0000_2000);
		sw(1'b0, 1'b0, 1'b1, 1'b0);
		wait_cyc(5);
		stops(1'b1, 1'b0);
		sw(1'b0, 1'b0, 1'b0, 1'b0);
		rdchk("flags stall", IDX_FLAGS, 32'h0000_0040);
		wait_cyc(3);
		stops(1'b0, 1'b0);
		rdchk("flags stall clr", IDX_FLAGS, 32'h0000_0000);
	endtask : t_stall

	// virtual limits on both sides
	task automatic t_vlim;
		apb(1'b1, IDX_LIM_L, 32'h0000_0100);
		apb(1'b1, IDX_LIM_R, 32'h0000_0200);
		settle(32'h0000_00C0);
		mot.ramp_pos <= 32'h0000_0080;
		sw(1'b0, 1'b0, 1'b0, 1'b1);
		wait_cyc(3);
		chk("halt left", 32'h0000_0001, {31'h0, cmd.limit_halt});
		chk("pos left", 32'h0000_0100, cmd.limit_pos);
		mot.ramp_pos <= 32'h0000_0300;
		sw(1'b0, 1'b0, 1'b0, 1'b0);
		wait_cyc(3);
		chk("halt right", 32'h0000_0001, {31'h0, cmd.limit_halt});
		chk("pos right", 32'h0000_0200, cmd.limit_pos);
		mot.ramp_pos <= 32'h0000_0180;
		wait_cyc(3);
		chk("halt none", 32'h0000_0000, {31'h0, cmd.limit_halt});
	endtask : t_vlim

	// clock enable low freezes the synchroniser and the stop outputs
	task automatic t_freeze;
		settle(32'h0000_0001);
		@(posedge pclk);
		ce_in <= 1'b0;
		sw(1'b1, 1'b0, 1'b0, 1'b1);
		wait_cyc(6);
		stops(1'b0, 1'b0);
		ce_in <= 1'b1;
		wait_cyc(5);
		stops(1'b1, 1'b0);
	endtask : t_freeze

	// guard against a hang anywhere
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		n_errors     = 0;
		total_checks = 0;
		presetn      = 1'b0;
		ce_in        = 1'b1;
		req          = '0;
		mot          = '0;
		{l_on, r_on, s_on, lo_l, lo_r} = 5'b00000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		wait_cyc(2);
		t_regs();
		t_left();
		t_right();
		t_disabled();
		t_stall();
		t_vlim();
		t_freeze();
		tally_and_finish();
	end
endmodule : reference_switch_stop_unit_tb

// File: testbench/switch_partner.sv
`timescale 1ns/1ps
// end switches and driver stall line, as seen at the unit's pins
module switch_partner (
	// clock
	input  wire logic pclk,
	// physical state wanted by the bench
	input  wire logic left_on,
	input  wire logic right_on,
	input  wire logic stall_on,
	input  wire logic low_l,
	input  wire logic low_r,
	// pins toward the unit
	output logic      stop_left_pin,
	output logic      stop_right_pin,
	output logic      stall_pin
);
	// an active-low switch pulls its pin to 0 when hit; pins move just after the edge
	always_ff @(posedge pclk) begin
		stop_left_pin  <= left_on ^ low_l;
		stop_right_pin <= right_on ^ low_r;
		stall_pin      <= stall_on;
	end
endmodule : switch_partner
